// >>> shared/sfr_map_pkg.sv
// Constants, register table and types for the data memory and register map.
`default_nettype none
package sfr_map_pkg;
  localparam int SFR_COUNT = 48;
  localparam int SLOT_W = 6;
  localparam int PROG_ADDR_W = 14;
  localparam logic [15:0] PROG_LAST = 16'h3fff;
  localparam logic [7:0] LOW_RAM_LAST = 8'h7f;
  localparam logic [7:0] RAM_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam logic [7:0] STACK_POINTER_OFS = 8'h81;
  localparam logic [7:0] POWER_CONTROL_OFS = 8'h87;
  localparam logic [7:0] PORT_ONE_LATCH_OFS = 8'h90;
  localparam logic [7:0] WATCHDOG_CLEAR_KEY_OFS = 8'h93;
  localparam logic [7:0] POWER_RESET_CONTROL_OFS = 8'haf;
  localparam logic [7:0] EP0_TX_DATA_OFS = 8'hea;
  localparam logic [7:0] EP0_RX_DATA_OFS = 8'hed;
  localparam logic [7:0] EP0_RX_COUNT_OFS = 8'hee;
  localparam logic [7:0] USB_DEVICE_ADDRESS_OFS = 8'hf2;
  localparam logic [7:0] STACK_POINTER_RST = 8'h07;
  localparam logic [7:0] POWER_RESET_CONTROL_RST = 8'h01;
  localparam logic [7:0] WATCHDOG_CLEAR_KEY_RST = 8'h55;
  localparam logic [7:0] RESET_CAUSE_FLAGS_RST = 8'h02;
  localparam logic [7:0] PORT0_PIN_CONFIG_RST = 8'hff;
  localparam logic [7:0] USB_FUNCTION_CONTROL_RST = 8'h01;
  localparam logic [7:0] WAKEUP_TIMER_CONFIG_RST = 8'h20;
  localparam logic [7:0] PORT_ONE_LATCH_RST = 8'h10;
  localparam int POWER_DOWN_BIT = 1;
  localparam int CPU_HALT_BIT = 0;
  localparam int LOW_VOLTAGE_RESET_BIT = 0;
  localparam int WATCHDOG_RUN_BIT = 2;

  typedef struct packed {
    logic [7:0] ofs;
    logic [7:0] rst;
    logic [7:0] wmask;
    logic [7:0] rmask;
    logic ext;
  } sfr_desc_t;

  // Offset, reset value, writable bits, readable bits, read from engine.
  localparam sfr_desc_t SFR_TABLE [SFR_COUNT] = '{
    '{8'h80, 8'h00, 8'hff, 8'hff, 1'b0},
    '{STACK_POINTER_OFS, STACK_POINTER_RST, 8'hff, 8'hff, 1'b0},
    '{8'h82, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'h83, 8'h00, 8'hff, 8'hff, 1'b0},
    '{POWER_CONTROL_OFS, 8'h00, 8'h03, 8'h03, 1'b0},
    '{8'h8e, 8'h00, 8'hff, 8'hff, 1'b0},
    '{PORT_ONE_LATCH_OFS, PORT_ONE_LATCH_RST, 8'h1f, 8'h1f, 1'b0},
    '{WATCHDOG_CLEAR_KEY_OFS, WATCHDOG_CLEAR_KEY_RST, 8'hff, 8'h00, 1'b0},
    '{8'h94, 8'h00, 8'h03, 8'h03, 1'b0},
    '{8'h95, WAKEUP_TIMER_CONFIG_RST, 8'h3f, 8'h3f, 1'b0},
    '{8'h96, RESET_CAUSE_FLAGS_RST, 8'h7f, 8'h7f, 1'b0},
    '{8'h9a, PORT0_PIN_CONFIG_RST, 8'hff, 8'hff, 1'b0},
    '{8'h9b, 8'h01, 8'h01, 8'h01, 1'b0},
    '{8'ha8, 8'h00, 8'h8b, 8'h8b, 1'b0},
    '{8'ha9, 8'h00, 8'h7f, 8'h7f, 1'b0},
    '{POWER_RESET_CONTROL_OFS, POWER_RESET_CONTROL_RST, 8'h05, 8'h05, 1'b0},
    '{8'hb3, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hbd, 8'h00, 8'h01, 8'h01, 1'b0},
    '{8'hbe, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hbf, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hd0, 8'h00, 8'hfd, 8'hfd, 1'b0},
    '{8'hd2, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hd3, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hd4, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hda, 8'h00, 8'h0b, 8'h0b, 1'b0},
    '{8'hdb, 8'h00, 8'h7f, 8'h7f, 1'b0},
    '{8'hdc, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hdd, 8'h00, 8'h06, 8'h06, 1'b0},
    '{8'hde, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'hdf, 8'h00, 8'h06, 8'h06, 1'b0},
    '{8'he0, 8'h00, 8'hff, 8'hff, 1'b0},
    '{8'he2, 8'h00, 8'hff, 8'h00, 1'b0},
    '{8'he3, 8'h00, 8'h0f, 8'h00, 1'b0},
    '{8'he4, 8'h00, 8'h0f, 8'h0f, 1'b0},
    '{8'he5, 8'h00, 8'hff, 8'h00, 1'b0},
    '{8'he6, 8'h00, 8'h0f, 8'h00, 1'b0},
    '{8'he7, 8'h00, 8'h0f, 8'h0f, 1'b0},
    '{8'he9, 8'h00, 8'h07, 8'h07, 1'b0},
    '{EP0_TX_DATA_OFS, 8'h00, 8'hff, 8'h00, 1'b0},
    '{8'heb, 8'h00, 8'h0f, 8'h00, 1'b0},
    '{8'hec, 8'h00, 8'h03, 8'h03, 1'b0},
    '{EP0_RX_DATA_OFS, 8'h00, 8'h00, 8'hff, 1'b1},
    '{EP0_RX_COUNT_OFS, 8'h00, 8'h00, 8'h0f, 1'b1},
    '{8'hef, 8'h00, 8'h3f, 8'h3f, 1'b0},
    '{8'hf0, 8'h00, 8'hff, 8'hff, 1'b0},
    '{USB_DEVICE_ADDRESS_OFS, 8'h00, 8'h7f, 8'h7f, 1'b0},
    '{8'hf3, USB_FUNCTION_CONTROL_RST, 8'hbb, 8'hbb, 1'b0},
    '{8'hf7, 8'h00, 8'hff, 8'hff, 1'b0}
  };

  typedef struct packed {
    logic hit;
    logic [SLOT_W-1:0] slot;
  } sfr_hit_t;

  typedef struct packed {
    logic req;
    logic we;
    logic indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [255:0][7:0] ram;
    logic [SFR_COUNT-1:0][7:0] sfr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [PROG_ADDR_W-1:0] flash_addr;
    logic flash_rd;
    logic fetch_fault;
    logic wdt_kick;
    logic ep0_tx_push;
  } state_t;
endpackage
`default_nettype wire

// >>> rtl/data_memory_and_sfr_map.sv
// Internal data RAM, register file and program fetch range of the controller.
`default_nettype none
module data_memory_and_sfr_map
  import sfr_map_pkg::*;
(
  input wire logic sys_clk, // System clock, 200 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire cpu_req_t cpu_in, // Data access from the core.
  input wire logic fetch_req, // Program fetch request.
  input wire logic [15:0] fetch_addr, // Program fetch address.
  input wire logic [7:0] ep0_rx_data, // Receive byte from the bus engine.
  input wire logic [3:0] ep0_rx_count, // Receive count from the bus engine.
  output logic [7:0] rd_data, // Read data, valid with rd_valid.
  output logic rd_valid, // One-cycle pulse after a read.
  output logic [PROG_ADDR_W-1:0] flash_addr, // Program memory address.
  output logic flash_rd, // Program memory read pulse.
  output logic fetch_fault, // Fetch outside program memory.
  output logic wdt_kick, // Pulse on a watchdog key write.
  output logic ep0_tx_push, // Pulse on an endpoint 0 transmit byte write.
  output logic power_down_request, // Power-down request level.
  output logic cpu_halt_request, // Halt request level.
  output logic watchdog_run_bit, // Watchdog enable level.
  output logic low_voltage_reset_on // Low-voltage reset enable level.
);

  state_t st_reg;
  state_t st_next;
  sfr_hit_t hit;
  logic sfr_path;

  // Finds the slot of a listed register; anything else is not storage.
  function automatic sfr_hit_t find_sfr(input logic [7:0] a);
    sfr_hit_t h;
    h = '0;
    for (int i = 0; i < SFR_COUNT; i++)
    begin
      if (SFR_TABLE[i].ofs == a)
      begin
        h.hit = 1'b1;
        h.slot = SLOT_W'(i);
      end
    end
    return h;
  endfunction

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int i = 0; i < 256; i++)
    begin
      s.ram[i] = RAM_RST;
    end
    // Every listed register takes its table reset value.
    for (int i = 0; i < SFR_COUNT; i++)
    begin
      s.sfr[i] = SFR_TABLE[i].rst;
    end
    return s;
  endfunction

  function automatic logic [7:0] sfr_read(input sfr_hit_t h, input state_t s,
                                          input logic [7:0] a,
                                          input logic [7:0] rxd,
                                          input logic [3:0] rxc);
    logic [7:0] v;
    v = UNMAPPED_READ;
    if (h.hit)
    begin
      if (SFR_TABLE[h.slot].ext)
      begin
        v = (a == EP0_RX_DATA_OFS) ? rxd : {4'h0, rxc};
      end
      else
      begin
        v = s.sfr[h.slot];
      end
      v = v & SFR_TABLE[h.slot].rmask;
    end
    return v;
  endfunction

  assign hit = find_sfr(cpu_in.addr);
  // Direct accesses above the lower RAM go to registers, all others to RAM.
  assign sfr_path = !cpu_in.indirect && (cpu_in.addr > LOW_RAM_LAST);

  always_comb
  begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.flash_rd = 1'b0;
    st_next.fetch_fault = 1'b0;
    st_next.wdt_kick = 1'b0;
    st_next.ep0_tx_push = 1'b0;
    if (cpu_in.req && cpu_in.we)
    begin
      if (!sfr_path)
      begin
        st_next.ram[cpu_in.addr] = cpu_in.wdata;
      end
      else if (hit.hit)
      begin
        st_next.sfr[hit.slot] = (st_reg.sfr[hit.slot] & ~SFR_TABLE[hit.slot].wmask)
          | (cpu_in.wdata & SFR_TABLE[hit.slot].wmask);
        st_next.wdt_kick = (cpu_in.addr == WATCHDOG_CLEAR_KEY_OFS);
        st_next.ep0_tx_push = (cpu_in.addr == EP0_TX_DATA_OFS);
      end
    end
    else if (cpu_in.req)
    begin
      st_next.rd_valid = 1'b1;
      st_next.rd_data = sfr_path
        ? sfr_read(hit, st_reg, cpu_in.addr, ep0_rx_data, ep0_rx_count)
        : st_reg.ram[cpu_in.addr];
    end
    if (fetch_req)
    begin
      if (fetch_addr <= PROG_LAST)
      begin
        st_next.flash_rd = 1'b1;
        st_next.flash_addr = fetch_addr[PROG_ADDR_W-1:0];
      end
      else
      begin
        st_next.fetch_fault = 1'b1;
      end
    end
    if (sys_rst)
    begin
      st_next = reset_state();
    end
  end

  always_ff @(posedge sys_clk)
  begin
    st_reg <= st_next;
  end

  assign rd_data = st_reg.rd_data;
  assign rd_valid = st_reg.rd_valid;
  assign flash_addr = st_reg.flash_addr;
  assign flash_rd = st_reg.flash_rd;
  assign fetch_fault = st_reg.fetch_fault;
  assign wdt_kick = st_reg.wdt_kick;
  assign ep0_tx_push = st_reg.ep0_tx_push;
  assign power_down_request = st_reg.sfr[4][POWER_DOWN_BIT];
  assign cpu_halt_request = st_reg.sfr[4][CPU_HALT_BIT];
  assign watchdog_run_bit = st_reg.sfr[15][WATCHDOG_RUN_BIT];
  assign low_voltage_reset_on = st_reg.sfr[15][LOW_VOLTAGE_RESET_BIT];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_write;
    cpu_in.req && cpu_in.we;
  endsequence

  sequence s_read;
    cpu_in.req && !cpu_in.we;
  endsequence

  sequence s_direct_read(logic [7:0] a);
    s_read ##0 (!cpu_in.indirect && cpu_in.addr == a);
  endsequence

  sequence s_direct_write(logic [7:0] a);
    s_write ##0 (!cpu_in.indirect && cpu_in.addr == a);
  endsequence

  a_low_ram_direct: assert property (
    s_write ##0 (!cpu_in.indirect && cpu_in.addr <= LOW_RAM_LAST)
    |=> st_reg.ram[$past(cpu_in.addr)] == $past(cpu_in.wdata))
    else $error("direct write to lower RAM lost");

  a_upper_ram_indirect: assert property (
    s_write ##0 cpu_in.indirect
    |=> st_reg.ram[$past(cpu_in.addr)] == $past(cpu_in.wdata) && $stable(st_reg.sfr))
    else $error("indirect write missed RAM or touched registers");

  a_direct_high_ram: assert property (
    s_write ##0 sfr_path |=> $stable(st_reg.ram))
    else $error("direct register write changed RAM");

  a_unmapped_write: assert property (
    s_write ##0 (sfr_path && !hit.hit) |=> $stable(st_reg.sfr) && !wdt_kick)
    else $error("write to unassigned address changed state");

  a_reset_values: assert property (
    $past(sys_rst) |-> st_reg.sfr[1] == STACK_POINTER_RST && st_reg.sfr[15]
      == POWER_RESET_CONTROL_RST && st_reg.sfr[7] == WATCHDOG_CLEAR_KEY_RST
      && !power_down_request && !cpu_halt_request && low_voltage_reset_on)
    else $error("register reset value wrong");

  a_power_control_high_zero: assert property (
    s_direct_read(POWER_CONTROL_OFS) |=> rd_valid && rd_data[7:2] == 6'h00)
    else $error("power control upper bits not zero");

  a_key_write_only: assert property (
    s_direct_read(WATCHDOG_CLEAR_KEY_OFS) |=> rd_valid && rd_data == 8'h00)
    else $error("watchdog key readable");

  a_key_kick_pulse: assert property (
    s_write ##0 (!cpu_in.indirect && cpu_in.addr == WATCHDOG_CLEAR_KEY_OFS)
    |=> wdt_kick ##1 (!wdt_kick || $past(cpu_in.req && cpu_in.we && !cpu_in.indirect
      && cpu_in.addr == WATCHDOG_CLEAR_KEY_OFS)))
    else $error("watchdog kick not a single pulse");

  a_addr_bit7_zero: assert property (
    s_direct_read(USB_DEVICE_ADDRESS_OFS) |=> !rd_data[7])
    else $error("device address bit 7 not zero");

  a_rx_count_read: assert property (
    s_direct_read(EP0_RX_COUNT_OFS)
    |=> rd_data == {4'h0, $past(ep0_rx_count)})
    else $error("receive count read wrong");

  a_port1_high_zero: assert property (
    s_direct_read(PORT_ONE_LATCH_OFS) |=> rd_data[7:5] == 3'h0)
    else $error("port 1 upper bits not zero");

  a_fetch_range: assert property (
    fetch_req |=> (flash_rd == ($past(fetch_addr) <= PROG_LAST))
      && (fetch_fault == !flash_rd))
    else $error("fetch range decision wrong");

  a_read_pulse: assert property (
    s_read ##0 cpu_in.indirect ##1 !cpu_in.req |-> rd_valid ##1 !rd_valid)
    else $error("read answer not a single pulse");

  // The checks below cover routing, masking and the pulse outputs one by one.
  a_low_ram_read: assert property (
    s_read ##0 (cpu_in.addr <= LOW_RAM_LAST)
    |=> rd_data == $past(st_reg.ram[cpu_in.addr]))
    else $error("lower RAM read returned wrong byte");

  a_upper_ram_read: assert property (
    s_read ##0 cpu_in.indirect |=> rd_data == $past(st_reg.ram[cpu_in.addr]))
    else $error("indirect read did not return RAM");

  a_sp_direct_write: assert property (
    s_direct_write(STACK_POINTER_OFS) |=> st_reg.sfr[1] == $past(cpu_in.wdata))
    else $error("direct write missed the stack pointer");

  a_write_silent: assert property (
    s_write |=> !rd_valid)
    else $error("write raised a read answer");

  a_read_no_change: assert property (
    s_read |=> $stable(st_reg.ram) && $stable(st_reg.sfr))
    else $error("read changed stored state");

  a_unmapped_read: assert property (
    s_read ##0 (sfr_path && !hit.hit) |=> rd_data == UNMAPPED_READ)
    else $error("unassigned register read not the fixed value");

  a_zero_bits_read: assert property (
    s_read ##0 (sfr_path && hit.hit)
    |=> (rd_data & ~SFR_TABLE[$past(hit.slot)].rmask) == 8'h00)
    else $error("fixed-zero bit read as one");

  a_zero_bits_kept: assert property (
    s_write ##0 (sfr_path && hit.hit)
    |=> ((st_reg.sfr[$past(hit.slot)] ^ $past(st_reg.sfr[hit.slot]))
      & ~SFR_TABLE[$past(hit.slot)].wmask) == 8'h00)
    else $error("write changed a fixed bit");

  a_power_control_levels: assert property (
    s_direct_write(POWER_CONTROL_OFS)
    |=> {power_down_request, cpu_halt_request} == $past(cpu_in.wdata[1:0]))
    else $error("power control levels do not follow the write");

  a_power_reset_control_levels: assert property (
    s_direct_write(POWER_RESET_CONTROL_OFS)
    |=> watchdog_run_bit == $past(cpu_in.wdata[WATCHDOG_RUN_BIT])
      && low_voltage_reset_on == $past(cpu_in.wdata[LOW_VOLTAGE_RESET_BIT]))
    else $error("power and reset control levels do not follow the write");

  a_kick_cause: assert property (
    wdt_kick |-> $past(cpu_in.req && cpu_in.we && !cpu_in.indirect
      && cpu_in.addr == WATCHDOG_CLEAR_KEY_OFS))
    else $error("watchdog kick without a key write");

  a_push_pulse: assert property (
    s_direct_write(EP0_TX_DATA_OFS) |=> ep0_tx_push)
    else $error("transmit byte write gave no push");

  a_push_cause: assert property (
    ep0_tx_push |-> $past(cpu_in.req && cpu_in.we && !cpu_in.indirect
      && cpu_in.addr == EP0_TX_DATA_OFS))
    else $error("push without a transmit byte write");

  a_tx_write_only: assert property (
    s_direct_read(EP0_TX_DATA_OFS) |=> rd_data == 8'h00)
    else $error("transmit byte readable");

  a_rx_data_read: assert property (
    s_direct_read(EP0_RX_DATA_OFS) |=> rd_data == $past(ep0_rx_data))
    else $error("receive byte read wrong");

  a_rx_read_only: assert property (
    s_write ##0 (!cpu_in.indirect
      && (cpu_in.addr == EP0_RX_DATA_OFS || cpu_in.addr == EP0_RX_COUNT_OFS))
    |=> $stable(st_reg.sfr))
    else $error("receive register took a write");

  a_fetch_load: assert property (
    fetch_req && fetch_addr <= PROG_LAST
    |=> flash_addr == $past(fetch_addr[PROG_ADDR_W-1:0]))
    else $error("fetch address not loaded");

  a_fetch_hold: assert property (
    fetch_req && fetch_addr > PROG_LAST |=> $stable(flash_addr))
    else $error("refused fetch moved the address");

  a_fetch_quiet: assert property (
    !fetch_req |=> !flash_rd && !fetch_fault)
    else $error("fetch pulse without a request");

  a_reset_others: assert property (
    $past(sys_rst) |-> st_reg.sfr[10] == RESET_CAUSE_FLAGS_RST
      && st_reg.sfr[9] == WAKEUP_TIMER_CONFIG_RST && st_reg.sfr[11] == PORT0_PIN_CONFIG_RST
      && st_reg.sfr[46] == USB_FUNCTION_CONTROL_RST && st_reg.sfr[6] == PORT_ONE_LATCH_RST
      && st_reg.sfr[30] == 8'h00 && st_reg.sfr[44] == 8'h00 && st_reg.sfr[20] == 8'h00)
    else $error("register reset value wrong after reset");

endmodule
`default_nettype wire

// >>> tb/usb_rx_engine_model.sv
// Stand-in for the bus engine that presents the endpoint 0 receive byte and count.
`default_nettype none
module usb_rx_engine_model (
  input wire logic sys_clk, // System clock.
  input wire logic load, // Capture a new packet byte.
  input wire logic [7:0] byte_in, // Byte to present.
  input wire logic [3:0] count_in, // Count to present.
  output logic [7:0] ep0_rx_data, // Receive byte level.
  output logic [3:0] ep0_rx_count // Receive count level.
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge sys_clk)
  begin
    if (load)
    begin
      ep0_rx_data <= byte_in;
      ep0_rx_count <= count_in;
    end
  end
endmodule
`default_nettype wire

// >>> tb/data_memory_and_sfr_map_tb_top.sv
// Self-checking bench for the data memory and register map.
`default_nettype none
module data_memory_and_sfr_map_tb_top;
  import sfr_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk;
  logic sys_rst;
  cpu_req_t cpu_in;
  logic fetch_req;
  logic [15:0] fetch_addr;
  logic rx_load;
  logic [7:0] rx_byte;
  logic [3:0] rx_cnt;
  logic [7:0] ep0_rx_data;
  logic [3:0] ep0_rx_count;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [PROG_ADDR_W-1:0] flash_addr;
  logic flash_rd, fetch_fault, wdt_kick, ep0_tx_push;
  logic power_down_request, cpu_halt_request, watchdog_run_bit, low_voltage_reset_on;
  int err_count;
  int n_compared;
  logic [15:0] rst_tab [16] = '{16'h8107, 16'h8200, 16'h8300, 16'h8700, 16'haf01, 16'h9300,
    16'h9602, 16'h9520, 16'hd400, 16'hf200, 16'hf301, 16'h9aff, 16'h9010, 16'he000,
    16'hf000, 16'hd000};
  logic [15:0] msk_tab [10] = '{16'h8703, 16'haf05, 16'hf27f, 16'h901f, 16'hd4ff, 16'h953f,
    16'h967f, 16'hf3bb, 16'hd0fd, 16'h81ff};

  data_memory_and_sfr_map dut_u (.sys_clk, .sys_rst, .cpu_in, .fetch_req, .fetch_addr,
    .ep0_rx_data, .ep0_rx_count, .rd_data, .rd_valid, .flash_addr, .flash_rd, .fetch_fault,
    .wdt_kick, .ep0_tx_push, .power_down_request, .cpu_halt_request, .watchdog_run_bit,
    .low_voltage_reset_on);

  usb_rx_engine_model engine_u (.sys_clk, .load(rx_load), .byte_in(rx_byte),
    .count_in(rx_cnt), .ep0_rx_data, .ep0_rx_count);

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One access: request raised after an edge, taken at the next, results read 1 ns later.
  task automatic acc(input logic we, input logic ind, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_in <= '{1'b1, we, ind, a, d};
    @(posedge sys_clk);
    cpu_in.req <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic ind, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, ind, a, 8'h00);
    chk($sformatf("valid_%h", a), 16'h1, {15'h0, rd_valid});
    chk($sformatf("data_%h_ind%b", a, ind), {8'h0, exp}, {8'h0, rd_data});
  endtask

  task automatic fetch(input logic [15:0] a);
    @(posedge sys_clk);
    fetch_req <= 1'b1;
    fetch_addr <= a;
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    #1;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    cpu_in = '0;
    fetch_req = 1'b0;
    fetch_addr = 16'h0000;
    rx_load = 1'b1;
    rx_byte = 8'hc3;
    rx_cnt = 4'h9;
    sys_rst = 1'b1;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rx_load <= 1'b0;
    #1;
    chk("lvr_on", 16'h1, {15'h0, low_voltage_reset_on});
    chk("wdt_run", 16'h0, {15'h0, watchdog_run_bit});
    foreach (rst_tab[i])
      rd(1'b0, rst_tab[i][15:8], rst_tab[i][7:0]);
    @(posedge sys_clk);
    #1;
    chk("valid_drop", 16'h0, {15'h0, rd_valid});
    foreach (msk_tab[i])
    begin
      acc(1'b1, 1'b0, msk_tab[i][15:8], 8'hff);
      rd(1'b0, msk_tab[i][15:8], msk_tab[i][7:0]);
    end
    chk("pd_hi", 16'h1, {15'h0, power_down_request});
    chk("wdt_hi", 16'h1, {15'h0, watchdog_run_bit});
    acc(1'b1, 1'b0, 8'h87, 8'h02);
    #5;
    chk("pd", 16'h1, {15'h0, power_down_request});
    chk("halt", 16'h0, {15'h0, cpu_halt_request});
    acc(1'b1, 1'b1, 8'h81, 8'h5a);
    rd(1'b0, 8'h81, 8'hff);
    rd(1'b1, 8'h81, 8'h5a);
    acc(1'b1, 1'b0, 8'he0, 8'ha5);
    rd(1'b1, 8'he0, 8'h00);
    rd(1'b0, 8'he0, 8'ha5);
    acc(1'b1, 1'b0, 8'h30, 8'haa);
    rd(1'b1, 8'h30, 8'haa);
    acc(1'b1, 1'b1, 8'h7f, 8'h3c);
    rd(1'b0, 8'h7f, 8'h3c);
    acc(1'b1, 1'b0, 8'h84, 8'h33);
    rd(1'b0, 8'h84, 8'h00);
    rd(1'b1, 8'h84, 8'h00);
    acc(1'b1, 1'b0, 8'h93, 8'haa);
    chk("kick", 16'h1, {15'h0, wdt_kick});
    @(posedge sys_clk);
    #1;
    chk("kick_end", 16'h0, {15'h0, wdt_kick});
    acc(1'b1, 1'b0, 8'hea, 8'h77);
    chk("push", 16'h1, {15'h0, ep0_tx_push});
    rd(1'b0, 8'hea, 8'h00);
    rd(1'b0, 8'h93, 8'h00);
    acc(1'b1, 1'b1, 8'h93, 8'h55);
    chk("kick_ind", 16'h0, {15'h0, wdt_kick});
    acc(1'b1, 1'b0, 8'hed, 8'h00);
    rd(1'b0, 8'hed, 8'hc3);
    rd(1'b0, 8'hee, 8'h09);
    fetch(16'h3fff);
    chk("flash_rd", 16'h1, {15'h0, flash_rd});
    chk("flash_addr", 16'h3fff, {2'b00, flash_addr});
    fetch(16'h4000);
    chk("fault", 16'h1, {15'h0, fetch_fault});
    chk("flash_rd_out", 16'h0, {15'h0, flash_rd});
    chk("flash_hold", 16'h3fff, {2'b00, flash_addr});
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    chk("pd_rst", 16'h0, {15'h0, power_down_request});
    chk("wdt_rst", 16'h0, {15'h0, watchdog_run_bit});
    chk("lvr_rst", 16'h1, {15'h0, low_voltage_reset_on});
    rd(1'b0, 8'h81, 8'h07);
    rd(1'b0, 8'h87, 8'h00);
    rd(1'b0, 8'haf, 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
